// *** aus_regs.sv ***
// module: APB register bank for ABR/UBR sharing and the sixteen VBR shapers
`timescale 1ns/1ps
module aus_regs #(
    parameter int unsigned SHAPERS = aus_pkg::NUM_SHAPERS
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [15:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [6:0] rx_fifo_cells_i,
    output logic rx_congested_o,
    input wire logic [15:0] ubr_active_vcs_i,
    input wire logic [31:0] mcr_sum_i,
    input wire logic frm_sent_i,
    input wire logic [15:0] frm_spacing_i,
    input wire logic [31:0] acr_i,
    input wire logic [31:0] nrm_i,
    input wire logic [31:0] vc_rate_i,
    output logic [31:0] abr_bw_o,
    output logic [31:0] ubr_bw_o,
    output logic [31:0] avg_spacing_o,
    output logic decay_hit_o,
    output logic [31:0] decayed_acr_o,
    output logic cong_exempt_o,
    input wire logic dev_wr_i,
    input wire logic [3:0] dev_shaper_i,
    input wire logic [31:0] dev_work_x_i,
    input wire logic [31:0] dev_work_y_i,
    input wire logic [15:0] dev_pc_low_i,
    input wire logic [3:0] dev_flags_i,
    output logic [15:0] shaper_enable_o,
    output logic [15:0] shaper_active_o,
    output logic [15:0] shaper_aggregate_o
);
    import aus_pkg::*;

    // byte-lane merge limited to the writable bits
    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] wd, input logic [3:0] strb,
        input logic [31:0] mask);
        logic [31:0] lanes;
        lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return ((old & ~(lanes & mask)) | (wd & lanes & mask));
    endfunction

    logic [31:0] avg_rate_q [SHAPERS];
    logic [31:0] work_x_q [SHAPERS];
    logic [31:0] work_y_q [SHAPERS];
    logic [31:0] peak_credit_q [SHAPERS];
    logic [31:0] prio_state_q [SHAPERS];
    logic [31:0] abr_inrate_q;
    logic [31:0] abr_outrate_q;
    logic [31:0] rx_lvl_q;
    logic [31:0] decay_q;
    logic [31:0] share_q;
    logic [31:0] total_q;
    logic [31:0] exempt_q;
    logic [31:0] rdata_d;
    logic [11:0] idx;
    logic [3:0] sh;
    logic [7:0] bank;
    logic aligned;
    logic wr_en;
    logic rd_en;
    logic hit;
    logic in_shaper;
    logic dev_same;
    logic [31:0] x_base;
    logic [31:0] y_base;
    logic [31:0] pc_base;
    logic [31:0] ps_base;

    aus_bw_if bw ();

    // byte address is four times the printed index
    assign idx = paddr_i[13:2];
    assign aligned = (paddr_i[1:0] == 2'b00) && (paddr_i[15:14] == 2'b00);
    assign sh = idx[3:0];
    assign bank = idx[11:4];
    assign in_shaper = aligned && (bank < 8'd5);
    assign hit = in_shaper || (aligned && (idx == IDX_ABR_INRATE
        || idx == IDX_ABR_OUTRATE || idx == IDX_RX_FIFO_LVL
        || idx == IDX_DECAY_CFG || idx == IDX_UBR_SHARE
        || idx == IDX_TOTAL_RATE || idx == IDX_EXEMPT_RATE));
    // zero wait states: access phase always completes in its first cycle
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !hit;
    assign wr_en = psel_i && penable_i && pwrite_i && hit;
    assign rd_en = psel_i && !penable_i && !pwrite_i;

    // host merge starts from the scheduler's same-cycle update, so a
    // priority-only write does not wipe flags the scheduler just set
    assign dev_same = dev_wr_i && (dev_shaper_i == sh);
    assign x_base = dev_same ? dev_work_x_i : work_x_q[sh];
    assign y_base = dev_same ? dev_work_y_i : work_y_q[sh];
    assign pc_base = dev_same ? {peak_credit_q[sh][31:CREDIT_LSB],
        dev_pc_low_i} : peak_credit_q[sh];
    assign ps_base = dev_same ? {prio_state_q[sh][31:AGM_BIT],
        dev_flags_i[3:1], prio_state_q[sh][ENABLE_BIT]} : prio_state_q[sh];

    always_comb begin
        rdata_d = 32'd0;
        if (in_shaper) begin
            unique case (bank)
                8'd0: rdata_d = avg_rate_q[sh];
                8'd1: rdata_d = work_x_q[sh];
                8'd2: rdata_d = work_y_q[sh];
                8'd3: rdata_d = peak_credit_q[sh];
                default: rdata_d = prio_state_q[sh];
            endcase
        end else if (aligned) begin
            unique case (idx)
                IDX_ABR_INRATE: rdata_d = abr_inrate_q;
                IDX_ABR_OUTRATE: rdata_d = abr_outrate_q;
                IDX_RX_FIFO_LVL: rdata_d = rx_lvl_q;
                IDX_DECAY_CFG: rdata_d = decay_q;
                IDX_UBR_SHARE: rdata_d = share_q;
                IDX_TOTAL_RATE: rdata_d = total_q;
                IDX_EXEMPT_RATE: rdata_d = exempt_q;
                default: rdata_d = 32'd0;
            endcase
        end
    end

    // read data registered in the setup cycle, valid through the access phase
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prdata_o <= 32'd0;
        end else if (rd_en) begin
            prdata_o <= rdata_d;
        end
    end

    // global configuration registers
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_lvl_q <= RST_RX_FIFO_LVL;
            decay_q <= RST_ZERO;
            share_q <= RST_UBR_SHARE;
            total_q <= RST_ZERO;
            exempt_q <= RST_ZERO;
            abr_inrate_q <= RST_ZERO;
            abr_outrate_q <= RST_ZERO;
        end else if (wr_en && !in_shaper) begin
            unique case (idx)
                IDX_RX_FIFO_LVL: rx_lvl_q <= merge(rx_lvl_q, pwdata_i,
                    pstrb_i, MASK_RX_FIFO_LVL);
                IDX_DECAY_CFG: decay_q <= merge(decay_q, pwdata_i,
                    pstrb_i, MASK_DECAY_CFG);
                IDX_UBR_SHARE: share_q <= merge(share_q, pwdata_i,
                    pstrb_i, MASK_UBR_SHARE);
                IDX_TOTAL_RATE: total_q <= merge(total_q, pwdata_i,
                    pstrb_i, MASK_RATE15);
                IDX_EXEMPT_RATE: exempt_q <= merge(exempt_q, pwdata_i,
                    pstrb_i, MASK_RATE15);
                IDX_ABR_INRATE: abr_inrate_q <= merge(abr_inrate_q,
                    pwdata_i, pstrb_i, MASK_ABR_PRIO);
                IDX_ABR_OUTRATE: abr_outrate_q <= merge(abr_outrate_q,
                    pwdata_i, pstrb_i, MASK_ABR_PRIO);
                default: ;
            endcase
        end
    end

    // shaper banks: the scheduler's write port updates working state; a host
    // write to the same word in the same cycle wins on the lanes it enables
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < SHAPERS; i++) begin
                avg_rate_q[i] <= RST_ZERO;
                work_x_q[i] <= RST_ZERO;
                work_y_q[i] <= RST_ZERO;
                peak_credit_q[i] <= RST_ZERO;
                prio_state_q[i] <= RST_ZERO;
            end
        end else begin
            if (dev_wr_i) begin
                work_x_q[dev_shaper_i] <= dev_work_x_i;
                work_y_q[dev_shaper_i] <= dev_work_y_i;
                peak_credit_q[dev_shaper_i][15:0] <= dev_pc_low_i;
                prio_state_q[dev_shaper_i][SCAN_BIT:ACTIVE_BIT]
                    <= dev_flags_i[3:1];
            end
            if (wr_en && in_shaper) begin
                unique case (bank)
                    8'd0: avg_rate_q[sh] <= merge(avg_rate_q[sh], pwdata_i,
                        pstrb_i, 32'hFFFF_FFFF);
                    8'd1: work_x_q[sh] <= merge(x_base, pwdata_i,
                        pstrb_i, 32'hFFFF_FFFF);
                    8'd2: work_y_q[sh] <= merge(y_base, pwdata_i,
                        pstrb_i, 32'hFFFF_FFFF);
                    8'd3: peak_credit_q[sh] <= merge(pc_base,
                        pwdata_i, pstrb_i, 32'hFFFF_FFFF);
                    default: prio_state_q[sh] <= merge(ps_base,
                        pwdata_i, pstrb_i, MASK_PRIO_STATE);
                endcase
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 16; i++) begin
            shaper_enable_o[i] = (i < SHAPERS)
                && prio_state_q[i][ENABLE_BIT];
            shaper_active_o[i] = (i < SHAPERS)
                && prio_state_q[i][ACTIVE_BIT];
            shaper_aggregate_o[i] = (i < SHAPERS)
                && prio_state_q[i][AGM_BIT];
        end
    end

    assign rx_congested_o = rx_fifo_cells_i >= rx_lvl_q[6:0];

    assign bw.ubr_vc_count_limit = share_q[UBR_LIMIT_LSB +: 16];
    assign bw.first_share_exponent = share_q[SHARE1_LSB +: 3];
    assign bw.second_share_exponent = share_q[SHARE2_LSB +: 3];
    assign bw.averaging_exponent = decay_q[AVG_EXP_LSB +: 3];
    assign bw.threshold_exponent = decay_q[THR_EXP_LSB +: 3];
    assign bw.total_rate = total_q[14:0];
    assign bw.exempt_rate = exempt_q[14:0];

    aus_rate_engine u_engine (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .cfg(bw),
        .ubr_active_vcs_i(ubr_active_vcs_i),
        .mcr_sum_i(mcr_sum_i),
        .frm_sent_i(frm_sent_i),
        .frm_spacing_i(frm_spacing_i),
        .acr_i(acr_i),
        .nrm_i(nrm_i),
        .vc_rate_i(vc_rate_i),
        .abr_bw_o(abr_bw_o),
        .ubr_bw_o(ubr_bw_o),
        .avg_spacing_o(avg_spacing_o),
        .decay_hit_o(decay_hit_o),
        .decayed_acr_o(decayed_acr_o),
        .cong_exempt_o(cong_exempt_o)
    );
endmodule

// *** aus_pkg.sv ***
// package: register map, field layout and reset values of the rate-control bank
package aus_pkg;
    localparam int unsigned NUM_SHAPERS = 16;
    localparam logic [11:0] IDX_AVG_RATE = 12'h000;
    localparam logic [11:0] IDX_WORK_X = 12'h010;
    localparam logic [11:0] IDX_WORK_Y = 12'h020;
    localparam logic [11:0] IDX_PEAK_CREDIT = 12'h030;
    localparam logic [11:0] IDX_PRIO_STATE = 12'h040;
    localparam logic [11:0] IDX_ABR_INRATE = 12'h050;
    localparam logic [11:0] IDX_ABR_OUTRATE = 12'h051;
    localparam logic [11:0] IDX_RX_FIFO_LVL = 12'h404;
    localparam logic [11:0] IDX_DECAY_CFG = 12'h405;
    localparam logic [11:0] IDX_UBR_SHARE = 12'h500;
    localparam logic [11:0] IDX_TOTAL_RATE = 12'h501;
    localparam logic [11:0] IDX_EXEMPT_RATE = 12'h502;
    localparam logic [31:0] MASK_RX_FIFO_LVL = 32'h0000_007F;
    localparam logic [31:0] MASK_DECAY_CFG = 32'h0000_003F;
    localparam logic [31:0] MASK_UBR_SHARE = 32'hFFFF_0F3F;
    localparam logic [31:0] MASK_RATE15 = 32'h0000_7FFF;
    localparam logic [31:0] MASK_PRIO_STATE = 32'hF800_001F;
    localparam logic [31:0] MASK_ABR_PRIO = 32'hF800_0004;
    localparam logic [31:0] RST_RX_FIFO_LVL = 32'h0000_007F;
    localparam logic [31:0] RST_UBR_SHARE = 32'h0000_0007;
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam int unsigned UBR_LIMIT_LSB = 16;
    localparam int unsigned ALLOC_LSB = 8;
    localparam int unsigned SHARE2_LSB = 3;
    localparam int unsigned SHARE1_LSB = 0;
    localparam int unsigned AVG_EXP_LSB = 3;
    localparam int unsigned THR_EXP_LSB = 0;
    localparam int unsigned PRIO_LSB = 27;
    localparam int unsigned AGM_BIT = 4;
    localparam int unsigned SCAN_BIT = 3;
    localparam int unsigned RR_BIT = 2;
    localparam int unsigned ACTIVE_BIT = 1;
    localparam int unsigned ENABLE_BIT = 0;
    localparam int unsigned CNT_LSB = 24;
    localparam int unsigned CREDIT_LSB = 16;
    // link capacity in cells per second (149.76 Mbit/s over 424-bit cells)
    localparam logic [31:0] LINK_CELLS_PER_S = 32'h0005_63B7;
endpackage

// *** aus_bw_if.sv ***
// interface: live configuration handed from the bank to the rate engine
`timescale 1ns/1ps
interface aus_bw_if;
    logic [15:0] ubr_vc_count_limit;
    logic [2:0] first_share_exponent;
    logic [2:0] second_share_exponent;
    logic [2:0] averaging_exponent;
    logic [2:0] threshold_exponent;
    logic [14:0] total_rate;
    logic [14:0] exempt_rate;
    modport bank (output ubr_vc_count_limit, first_share_exponent,
        second_share_exponent, averaging_exponent, threshold_exponent,
        total_rate, exempt_rate);
    modport engine (input ubr_vc_count_limit, first_share_exponent,
        second_share_exponent, averaging_exponent, threshold_exponent,
        total_rate, exempt_rate);
endinterface

// *** aus_rate_engine.sv ***
// module: bandwidth split, idle-rate decay and congestion exemption arithmetic
`timescale 1ns/1ps
module aus_rate_engine (
    input wire logic clk_i,
    input wire logic nrst_i,
    aus_bw_if.engine cfg,
    input wire logic [15:0] ubr_active_vcs_i,
    input wire logic [31:0] mcr_sum_i,
    input wire logic frm_sent_i,
    input wire logic [15:0] frm_spacing_i,
    input wire logic [31:0] acr_i,
    input wire logic [31:0] nrm_i,
    input wire logic [31:0] vc_rate_i,
    output logic [31:0] abr_bw_o,
    output logic [31:0] ubr_bw_o,
    output logic [31:0] avg_spacing_o,
    output logic decay_hit_o,
    output logic [31:0] decayed_acr_o,
    output logic cong_exempt_o
);
    import aus_pkg::*;

    // 15-bit flag/exponent/mantissa rate to cells per second, saturating
    function automatic logic [31:0] rate_to_cps(input logic [14:0] r);
        logic [40:0] v;
        v = 41'd0;
        if (r[14]) begin
            v = ({31'd0, 1'b1, r[8:0]} << r[13:9]) >> 9;
        end
        return (v[40:32] != 9'd0) ? 32'hFFFF_FFFF : v[31:0];
    endfunction

    logic [31:0] total_cps;
    logic [31:0] excess;
    logic [31:0] share1;
    logic [31:0] share2;
    logic [31:0] abr_d;
    logic [31:0] ubr_d;
    logic [31:0] avg_q;
    logic [31:0] avg_d;
    logic [47:0] lhs;
    logic [47:0] rhs;
    logic [31:0] acr_safe;

    assign total_cps = rate_to_cps(cfg.total_rate);
    assign excess = (total_cps > mcr_sum_i) ? total_cps - mcr_sum_i : 32'd0;
    // share1 = excess*(1-2^-e1), share2 = excess*2^-e2
    assign share1 = excess - (excess >> cfg.first_share_exponent);
    assign share2 = excess >> cfg.second_share_exponent;
    always_comb begin
        if (ubr_active_vcs_i == 16'd0) begin
            abr_d = total_cps;
            ubr_d = 32'd0;
        end else if (ubr_active_vcs_i < cfg.ubr_vc_count_limit) begin
            abr_d = share1 + mcr_sum_i;
            ubr_d = excess - share1;
        end else begin
            abr_d = share2 + mcr_sum_i;
            ubr_d = excess - share2;
        end
    end

    // avg += (T - avg) >> a, written without signed hazards
    always_comb begin
        if ({16'd0, frm_spacing_i} >= avg_q) begin
            avg_d = avg_q + (({16'd0, frm_spacing_i} - avg_q)
                >> cfg.averaging_exponent);
        end else begin
            avg_d = avg_q - ((avg_q - {16'd0, frm_spacing_i})
                >> cfg.averaging_exponent);
        end
    end

    // compare Clink*Nrm/ACR <= Ta*b as Clink*Nrm <= Ta*b*ACR
    assign acr_safe = (acr_i == 32'd0) ? 32'd1 : acr_i;
    assign lhs = 48'({16'd0, LINK_CELLS_PER_S} * {16'd0, nrm_i});
    assign rhs = 48'({16'd0, avg_q - (avg_q >> cfg.threshold_exponent)}
        * {16'd0, acr_safe});

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            avg_q <= 32'd0;
            abr_bw_o <= 32'd0;
            ubr_bw_o <= 32'd0;
            decay_hit_o <= 1'b0;
            decayed_acr_o <= 32'd0;
            cong_exempt_o <= 1'b0;
        end else begin
            if (frm_sent_i) begin
                avg_q <= avg_d;
            end
            abr_bw_o <= abr_d;
            ubr_bw_o <= ubr_d;
            decay_hit_o <= (avg_q != 32'd0) && (lhs <= rhs);
            decayed_acr_o <= ((avg_q != 32'd0) && (lhs <= rhs))
                ? acr_i - (acr_i >> 4) : acr_i;
            cong_exempt_o <= vc_rate_i < rate_to_cps(cfg.exempt_rate);
        end
    end
    assign avg_spacing_o = avg_q;
endmodule

// *** aus_regs_props.sv ***
// checker: port-level properties of the rate-control register bank
`timescale 1ns/1ps
module aus_regs_props #(
    parameter int unsigned SHAPERS = 16
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [15:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pslverr_o,
    input wire logic [15:0] ubr_active_vcs_i,
    input wire logic [31:0] mcr_sum_i,
    input wire logic [31:0] abr_bw_o,
    input wire logic [31:0] ubr_bw_o,
    input wire logic frm_sent_i,
    input wire logic [31:0] avg_spacing_o,
    input wire logic [31:0] acr_i,
    input wire logic decay_hit_o,
    input wire logic [31:0] decayed_acr_o,
    input wire logic [31:0] vc_rate_i,
    input wire logic cong_exempt_o,
    input wire logic dev_wr_i,
    input wire logic [3:0] dev_shaper_i,
    input wire logic [3:0] dev_flags_i,
    input wire logic [15:0] shaper_enable_o,
    input wire logic [15:0] shaper_active_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);
    wire logic acc = psel_i && penable_i;
    wire logic host_wr = acc && pwrite_i;
    chk_err_phase: assert property (!acc |-> !pslverr_o)
        else $error("slave error outside access phase");
    chk_err_unaligned: assert property (acc && paddr_i[1:0] != 2'b00
        |-> pslverr_o) else $error("unaligned access not refused");
    chk_err_mapped: assert property (acc && paddr_i == 16'h1010
        |-> !pslverr_o) else $error("mapped access refused");
    chk_err_rdata: assert property (acc && !pwrite_i && pslverr_o
        |-> prdata_o == 32'h0000_0000) else $error("refused read not zero");
    chk_idle_ubr: assert property ($past(nrst_i) &&
        $past(ubr_active_vcs_i) == 16'h0000 |-> ubr_bw_o == 32'h0000_0000)
        else $error("ubr share with no active channel");
    chk_abr_floor: assert property ($past(nrst_i) &&
        $past(ubr_active_vcs_i) != 16'h0000 |-> abr_bw_o >= $past(mcr_sum_i))
        else $error("abr share below mcr sum");
    chk_decay_cut: assert property ($past(nrst_i) && decay_hit_o
        |-> decayed_acr_o == $past(acr_i) - ($past(acr_i) >> 4))
        else $error("decayed rate not fifteen sixteenths");
    chk_decay_pass: assert property ($past(nrst_i) && !decay_hit_o
        |-> decayed_acr_o == $past(acr_i)) else $error("rate cut without hit");
    chk_exempt_top: assert property ($past(nrst_i) &&
        $past(vc_rate_i) == 32'hFFFF_FFFF |-> !cong_exempt_o)
        else $error("top rate taken as below exempt rate");
    chk_avg_hold: assert property ($past(nrst_i) && !$past(frm_sent_i)
        |-> $stable(avg_spacing_o)) else $error("average moved");
    chk_enable_hold: assert property ($past(nrst_i) && !$past(host_wr)
        |-> $stable(shaper_enable_o)) else $error("enable moved");
    chk_dev_active: assert property ($past(nrst_i && dev_wr_i && !host_wr)
        |-> shaper_active_o[$past(dev_shaper_i)] == $past(dev_flags_i[1]))
        else $error("device active flag lost");
endmodule

bind aus_regs aus_regs_props #(.SHAPERS(SHAPERS)) i_aus_regs_props (
    .clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .prdata_o,
    .pslverr_o, .ubr_active_vcs_i, .mcr_sum_i, .abr_bw_o, .ubr_bw_o,
    .frm_sent_i, .avg_spacing_o, .acr_i, .decay_hit_o, .decayed_acr_o,
    .vc_rate_i, .cong_exempt_o, .dev_wr_i, .dev_shaper_i, .dev_flags_i,
    .shaper_enable_o, .shaper_active_o);

// *** tb.sv ***
// testbench: register map, bandwidth split and rate checks of aus_regs
`timescale 1ns/1ps
module tb;
    logic clk_i = 0;
    logic nrst_i = 0;
    logic psel_i = 0, penable_i = 0, pwrite_i = 0, frm_sent_i = 0;
    logic [15:0] paddr_i = '0, frm_spacing_i = '0, dev_pc_low_i = '0;
    logic [31:0] pwdata_i = '0, mcr_sum_i = '0, acr_i = '0, nrm_i = '0;
    logic [31:0] vc_rate_i = '0, dev_work_x_i = '0, dev_work_y_i = '0;
    logic [3:0] pstrb_i = '0, dev_shaper_i = '0, dev_flags_i = '0;
    logic [6:0] rx_fifo_cells_i = '0;
    logic [15:0] ubr_active_vcs_i = '0;
    logic dev_wr_i = 0;
    logic [31:0] prdata_o, abr_bw_o, ubr_bw_o, avg_spacing_o, decayed_acr_o;
    logic pready_o, pslverr_o, rx_congested_o, decay_hit_o, cong_exempt_o;
    logic [15:0] shaper_enable_o, shaper_active_o, shaper_aggregate_o;
    int mismatches = 0;
    int n_compared = 0;
    logic [31:0] rd;
    logic err;

    aus_regs i_aus_regs (.*);

    always #2 clk_i = ~clk_i;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        if (mismatches == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // one transfer; waits for pready, only the watchdog ends a hang
    task automatic apb(input logic w, input logic [15:0] a,
        input logic [31:0] d, input logic [3:0] s);
        @(posedge clk_i);
        psel_i <= 1;
        penable_i <= 0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        pstrb_i <= s;
        @(posedge clk_i);
        penable_i <= 1;
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 0;
        penable_i <= 0;
    endtask

    task automatic wr(input logic [11:0] i, input logic [31:0] d);
        apb(1'b1, {2'b00, i, 2'b00}, d, 4'hF);
    endtask

    task automatic rchk(input logic [11:0] i, input logic [31:0] e);
        apb(1'b0, {2'b00, i, 2'b00}, 32'h0, 4'h0);
        chk(rd, e);
    endtask

    task automatic t_defaults();
        rchk(12'h404, 32'h0000_007F);
        rchk(12'h405, 32'h0000_0000);
        rchk(12'h500, 32'h0000_0007);
        rchk(12'h501, 32'h0000_0000);
        rchk(12'h502, 32'h0000_0000);
        for (int b = 0; b < 5; b++)
            rchk(12'(b * 16 + 15), 32'h0000_0000);
        rchk(12'h051, 32'h0000_0000);
    endtask

    // host never sets scan, round-robin or active flags here
    task automatic t_masks();
        logic [11:0] ix[7] = '{12'h404, 12'h405, 12'h500, 12'h501,
            12'h502, 12'h04A, 12'h050};
        logic [31:0] mk[7] = '{32'h0000_007F, 32'h0000_003F,
            32'hFFFF_0F3F, 32'h0000_7FFF, 32'h0000_7FFF, 32'hF800_0011,
            32'hF800_0000};
        for (int k = 0; k < 7; k++) begin
            wr(ix[k], ix[k][11:8] == 4'h0 ? 32'hFFFF_FFF1 : 32'hFFFF_FFFF);
            rchk(ix[k], mk[k]);
        end
        chk({16'h0, shaper_enable_o}, 32'h0000_0400);
        chk({16'h0, shaper_aggregate_o}, 32'h0000_0400);
        wr(12'h04A, 32'h0000_0000);
    endtask

    task automatic t_lanes();
        wr(12'h002, 32'hFFFF_FFFF);
        apb(1'b1, 16'h0008, 32'h0000_0000, 4'b0101);
        rchk(12'h002, 32'hFF00_FF00);
        wr(12'h042, 32'h0000_0001); // working state zero since reset
        apb(1'b1, 16'h0108, 32'hFFFF_FFFE, 4'b1000);
        rchk(12'h042, 32'hF800_0001);
        chk({16'h0, shaper_enable_o}, 32'h0000_0004);
        // active read back as 0: disable and clear state, then new rate
        wr(12'h042, 32'hF800_0000);
        wr(12'h002, 32'h0400_0100);
        rchk(12'h002, 32'h0400_0100);
        chk({16'h0, shaper_enable_o}, 32'h0000_0000);
    endtask

    task automatic t_refused();
        apb(1'b0, 16'h0148, 32'h0, 4'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, 16'h1012, 32'h0000_0001, 4'hF);
        chk({31'h0, err}, 32'h1);
        rchk(12'h404, 32'h0000_007F);
    endtask

    task automatic t_device();
        wr(12'h033, 32'h0510_0000);
        @(posedge clk_i);
        dev_wr_i <= 1;
        dev_shaper_i <= 4'h3;
        dev_work_x_i <= 32'h1234_5678;
        dev_work_y_i <= 32'h9ABC_DEF0;
        dev_pc_low_i <= 16'hA55A;
        dev_flags_i <= 4'hE;
        @(posedge clk_i);
        dev_wr_i <= 0;
        rchk(12'h013, 32'h1234_5678);
        rchk(12'h023, 32'h9ABC_DEF0);
        rchk(12'h033, 32'h0510_A55A);
        rchk(12'h043, 32'h0000_000E);
        chk({16'h0, shaper_active_o}, 32'h0000_0008);
    endtask

    task automatic t_congest();
        wr(12'h404, 32'h0000_0005);
        for (int k = 4; k < 7; k++) begin
            @(posedge clk_i);
            rx_fifo_cells_i <= 7'(k);
            @(posedge clk_i);
            chk({31'h0, rx_congested_o}, 32'(k >= 5));
        end
    endtask

    // 1024 cells/s total, 24 cells/s reserved, limit 4, exponents 2 and 1
    task automatic t_split();
        logic [15:0] nv[4] = '{16'd0, 16'd3, 16'd4, 16'd9};
        logic [31:0] ea[4] = '{32'd1024, 32'd774, 32'd524, 32'd524};
        logic [31:0] eu[4] = '{32'd0, 32'd250, 32'd500, 32'd500};
        wr(12'h501, 32'h0000_5400);
        wr(12'h500, 32'h0004_000A);
        mcr_sum_i <= 32'd24;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_i);
            ubr_active_vcs_i <= nv[k];
            repeat (2) @(posedge clk_i);
            chk(abr_bw_o, ea[k]);
            chk(ubr_bw_o, eu[k]);
        end
    endtask

    task automatic t_exempt();
        logic [31:0] rr[4] = '{32'h0000_5400, 32'h0000_5400, 32'h0000_1400,
            32'h0000_7FFF};
        logic [31:0] vr[4] = '{32'd1023, 32'd1024, 32'd1023, 32'hFFFF_FFFF};
        for (int k = 0; k < 4; k++) begin
            wr(12'h502, rr[k]);
            vc_rate_i <= vr[k];
            repeat (2) @(posedge clk_i);
            chk({31'h0, cong_exempt_o}, 32'(k == 0));
        end
    endtask

    task automatic t_decay();
        wr(12'h405, 32'h0000_0009);
        nrm_i <= 32'd1;
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_i);
            frm_sent_i <= 1;
            frm_spacing_i <= 16'd64;
            @(posedge clk_i);
            frm_sent_i <= 0;
            @(posedge clk_i);
            chk(avg_spacing_o, k ? 32'd48 : 32'd32);
        end
        acr_i <= 32'd20000;
        repeat (2) @(posedge clk_i);
        chk({31'h0, decay_hit_o}, 32'h1);
        chk(decayed_acr_o, 32'd18750);
        acr_i <= 32'd14000;
        repeat (2) @(posedge clk_i);
        chk({31'h0, decay_hit_o}, 32'h0);
        chk(decayed_acr_o, 32'd14000);
    endtask

    initial begin
        repeat (8) @(posedge clk_i);
        nrst_i <= 1;
        t_defaults();
        t_masks();
        t_lanes();
        t_refused();
        t_device();
        t_congest();
        t_split();
        t_exempt();
        t_decay();
        conclude();
    end

    // whole run needs well under 2000 cycles
    initial begin
        #100000;
        mismatches++;
        conclude();
    end
endmodule
